// [rsq_top.sv]
// Reset sequencer with supply monitor flags and an AXI4-Lite register port.
// Assumes comparator and watchdog inputs synchronous to clk_i; the reset
// pin is open drain and resolved outside from rst_pin_o and rst_pin_oe_o.
// Contract
// - Every reset source drives pin; low through delay; an outside-only request is not driven until the delay phase
// - Start address fetched from FFFEh-FFFFh
// - Delay of 256 or 4096 cycles by option
// - Vector fetch lasts exactly two cycles
// - External pin low detected without a clock
// - Watchdog underflow drives pin low minimum width
// - Under-threshold supply holds device in static reset
// - Low-supply reset holds the pin low
// - Low-supply reset exists only when option enables
// - Aux flag follows comparator, read-only
// - Aux detector works only with low-supply enabled
// - Interrupt on every aux flag toggle when enabled
// - No aux interrupt for crossing during delay
// - Enable while low gives enable interrupt too
// - Enable after crossing gives only one interrupt
// - Main oscillator keeps running during reset
// - PLL enabled by option or software bit
// - PLL doubles 8 MHz input to 16 MHz
// - Pending aux interrupt cleared on service entry
// - Sticky low-supply flag, cleared only by software
// - Watchdog flag cleared by software or low-supply
`timescale 1ns/1ps
`include "rsq_map.svh"

module rsq_top
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	input wire logic low_supply_i,
	input wire logic aux_low_i,
	input wire logic wdg_underflow_i,
	input wire logic opt_lvd_en_i,
	input wire logic opt_long_dly_i,
	input wire logic opt_pll_en_i,
	input wire logic irq_ack_i,
	output logic core_rst_n_o,
	output logic vec_fetch_o,
	output logic [15:0] vec_addr_o,
	output logic aux_irq_o,
	output logic pll_en_o,
	output logic osc_en_o,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	rsq_pkg::rsq_state_t state;
	rsq_pkg::rsq_state_t next_state;
	logic ext_req;
	logic ext_arst_n;
	logic lvd_act;
	logic [`RSQ_WDG_CNT_W-1:0] wdg_cnt;
	logic wdg_act;
	logic src_act;
	logic [12:0] dly_cnt;
	logic [12:0] dly_len;
	logic dly_done;
	logic aux_flag;
	logic irq_en;
	logic irq_en_d;
	logic lsr_flag;
	logic wdg_flag;
	logic sw_pll_en;
	logic aw_held;
	logic w_held;
	logic [`RSQ_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic wr_byte0;
	logic wr_ics;
	logic wr_pll;
	logic wr_hit;
	logic [31:0] rd_word;
	logic rd_hit;

	// Pin low while the pin is ours does not count as an outside request
	assign ext_arst_n = arst_n_i & (rst_pin_i | rst_pin_oe_o);

	// Clockless pin capture
	// The flop is set by the pin itself, so a halted clock cannot miss it
	always_ff @(posedge clk_i or negedge ext_arst_n)
	begin
		if (!ext_arst_n)
			ext_req <= 1'b1;
		else
			ext_req <= 1'b0;
	end

	assign lvd_act = opt_lvd_en_i & low_supply_i;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			wdg_cnt <= '0;
		else if (wdg_underflow_i)
			wdg_cnt <= `RSQ_WDG_CNT_W'(`RSQ_TW_OUT_CYC);
		else if (wdg_cnt != '0)
			wdg_cnt <= wdg_cnt - `RSQ_WDG_CNT_W'(1);
	end

	assign wdg_act = wdg_underflow_i | (wdg_cnt != '0);
	// The capture flop is also set by system reset; it only stands for an
	// outside request while the pin is not ours, else the pin would be
	// released for one cycle before the delay phase
	assign src_act = (ext_req & !rst_pin_oe_o) | lvd_act | wdg_act;

	assign dly_len = opt_long_dly_i ? `RSQ_DLY_LONG : `RSQ_DLY_SHORT;
	assign dly_done = (dly_cnt == dly_len - `RSQ_DLY_ONE);

	always_comb
	begin
		next_state = state;
		unique case (state)
			rsq_pkg::RSQ_ACTIVE:
				if (!src_act)
					next_state = rsq_pkg::RSQ_DELAY;
			rsq_pkg::RSQ_DELAY:
				if (src_act)
					next_state = rsq_pkg::RSQ_ACTIVE;
				else if (dly_done)
					next_state = rsq_pkg::RSQ_FETCH0;
			rsq_pkg::RSQ_FETCH0:
				if (src_act)
					next_state = rsq_pkg::RSQ_ACTIVE;
				else
					next_state = rsq_pkg::RSQ_FETCH1;
			rsq_pkg::RSQ_FETCH1:
				if (src_act)
					next_state = rsq_pkg::RSQ_ACTIVE;
				else
					next_state = rsq_pkg::RSQ_RUN;
			rsq_pkg::RSQ_RUN:
				if (src_act)
					next_state = rsq_pkg::RSQ_ACTIVE;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state <= rsq_pkg::RSQ_ACTIVE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			dly_cnt <= '0;
		else if (state == rsq_pkg::RSQ_DELAY && !src_act)
			dly_cnt <= dly_cnt + `RSQ_DLY_ONE;
		else
			dly_cnt <= '0;
	end

	// Low-supply holds pin
	// An outside-only request is not driven in the active phase, so its
	// release stays visible on the pin.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rst_pin_oe_o <= 1'b1;
		else
			rst_pin_oe_o <= (next_state == rsq_pkg::RSQ_DELAY) |
				(next_state == rsq_pkg::RSQ_ACTIVE & (lvd_act | wdg_act));
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rst_pin_o <= 1'b0;
		else
			rst_pin_o <= 1'b0;
	end

	// Core reset drops at once on an outside pin request
	always_ff @(posedge clk_i or negedge ext_arst_n)
	begin
		if (!ext_arst_n)
			core_rst_n_o <= 1'b0;
		else
			core_rst_n_o <= (next_state == rsq_pkg::RSQ_RUN);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			vec_fetch_o <= 1'b0;
			vec_addr_o <= `RSQ_VEC_HI;
		end
		else
		begin
			vec_fetch_o <= (next_state == rsq_pkg::RSQ_FETCH0) |
				(next_state == rsq_pkg::RSQ_FETCH1);
			vec_addr_o <= (next_state == rsq_pkg::RSQ_FETCH1) ?
				`RSQ_VEC_LO : `RSQ_VEC_HI;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			osc_en_o <= 1'b1;
		else
			osc_en_o <= 1'b1;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			pll_en_o <= 1'b0;
		else
			pll_en_o <= opt_pll_en_i | sw_pll_en;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			aux_flag <= 1'b0;
		else
			aux_flag <= opt_lvd_en_i & aux_low_i;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			irq_en_d <= 1'b0;
		else
			irq_en_d <= irq_en;
	end

	// Cleared on service entry
	// A new event in the acknowledge cycle wins over the clear.
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			aux_irq_o <= 1'b0;
		else if (opt_lvd_en_i & irq_en &
			((state == rsq_pkg::RSQ_RUN &
			(aux_flag != (opt_lvd_en_i & aux_low_i))) |
			(!irq_en_d & aux_flag)))
			aux_irq_o <= 1'b1;
		else if (irq_ack_i | !irq_en)
			aux_irq_o <= 1'b0;
	end

	// Register write side
	assign wr_go = aw_held & w_held & !s_axi_bvalid;
	assign wr_byte0 = wr_go & w_strb[0];
	assign wr_ics = wr_byte0 & (aw_addr == `RSQ_OFF_ICS);
	assign wr_pll = wr_byte0 & (aw_addr == `RSQ_OFF_PLL);
	assign wr_hit = (aw_addr == `RSQ_OFF_ICS) |
		(aw_addr == `RSQ_OFF_PLL) | (aw_addr == `RSQ_OFF_SEQ);

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_en <= 1'b0;
			sw_pll_en <= 1'b0;
		end
		else
		begin
			if (wr_ics)
				irq_en <= w_data[`RSQ_ICS_IRQ_EN];
			if (wr_pll)
				sw_pll_en <= w_data[`RSQ_PLL_SW_EN];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			lsr_flag <= 1'b0;
		else if (lvd_act)
			lsr_flag <= 1'b1;
		else if (wr_ics & !w_data[`RSQ_ICS_LSR_FLAG])
			lsr_flag <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			wdg_flag <= 1'b0;
		else if (wdg_underflow_i)
			wdg_flag <= 1'b1;
		else if (lvd_act)
			wdg_flag <= 1'b0;
		else if (wr_ics & !w_data[`RSQ_ICS_WDG_FLAG])
			wdg_flag <= 1'b0;
	end

	// Address and data are caught independently, in either order
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid & s_axi_awready)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr[`RSQ_ADDR_W-1:0];
		end
		else if (wr_go)
			aw_held <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid & s_axi_wready)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		else if (wr_go)
			w_held <= 1'b0;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end
		else
		begin
			s_axi_awready <= !aw_held & !(s_axi_awvalid & s_axi_awready)
				& !s_axi_bvalid;
			s_axi_wready <= !w_held & !(s_axi_wvalid & s_axi_wready)
				& !s_axi_bvalid;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RSQ_RESP_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Register read side
	always_comb
	begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr[`RSQ_ADDR_W-1:0])
			`RSQ_OFF_ICS:
			begin
				rd_word[`RSQ_ICS_IRQ_EN] = irq_en;
				rd_word[`RSQ_ICS_AUX_FLAG] = aux_flag;
				rd_word[`RSQ_ICS_LSR_FLAG] = lsr_flag;
				rd_word[`RSQ_ICS_WDG_FLAG] = wdg_flag;
			end
			`RSQ_OFF_PLL:
			begin
				rd_word[`RSQ_PLL_SW_EN] = sw_pll_en;
				rd_word[`RSQ_PLL_ON] = pll_en_o;
				rd_word[`RSQ_PLL_RATIO_LO +: 2] =
					2'(`RSQ_PLL_OUT_MHZ / `RSQ_PLL_IN_MHZ);
			end
			`RSQ_OFF_SEQ:
			begin
				rd_word[`RSQ_SEQ_RUN] = (state == rsq_pkg::RSQ_RUN);
				rd_word[`RSQ_SEQ_LONG] = opt_long_dly_i;
				rd_word[`RSQ_SEQ_PIN] = rst_pin_oe_o;
			end
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			s_axi_arready <= 1'b0;
		else
			s_axi_arready <= !s_axi_rvalid & !(s_axi_arvalid & s_axi_arready);
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `RSQ_RESP_OKAY;
		end
		else if (s_axi_arvalid & s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? `RSQ_RESP_OKAY : `RSQ_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // rsq_top

// [rsq_map.svh]
// Register offsets, field positions and timing counts of the reset sequencer.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port.
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

`define RSQ_CLK_MHZ 100
`define RSQ_ADDR_W 4
`define RSQ_OFF_ICS 4'h0
`define RSQ_OFF_PLL 4'h4
`define RSQ_OFF_SEQ 4'h8

`define RSQ_ICS_IRQ_EN 6
`define RSQ_ICS_AUX_FLAG 5
`define RSQ_ICS_LSR_FLAG 4
`define RSQ_ICS_WDG_FLAG 0
`define RSQ_PLL_SW_EN 3
`define RSQ_PLL_ON 4
`define RSQ_PLL_RATIO_LO 5
`define RSQ_SEQ_RUN 0
`define RSQ_SEQ_LONG 1
`define RSQ_SEQ_PIN 2

`define RSQ_DLY_SHORT 13'h0100
`define RSQ_DLY_LONG 13'h1000
`define RSQ_DLY_ONE 13'h0001
`define RSQ_VEC_HI 16'hFFFE
`define RSQ_VEC_LO 16'hFFFF

`define RSQ_TW_OUT_NS 30
`define RSQ_TW_OUT_CYC ((`RSQ_TW_OUT_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_WDG_CNT_W 4

`define RSQ_PLL_IN_MHZ 8
`define RSQ_PLL_OUT_MHZ 16

`define RSQ_RESP_OKAY 2'h0
`define RSQ_RESP_SLVERR 2'h2

`endif

// [rsq_pkg.sv]
// Types shared by the reset sequencer.
// Assumes rsq_map.svh supplies the numeric constants.
package rsq_pkg;
	typedef enum logic [2:0] {
		RSQ_ACTIVE,
		RSQ_DELAY,
		RSQ_FETCH0,
		RSQ_FETCH1,
		RSQ_RUN
	} rsq_state_t;
endpackage

// [rsq_assertions.sv]
// Concurrent checks on the reset sequencer ports.
// Assumes a bind to rsq_top; one clock domain, reset low active.
`timescale 1ns/1ps
`include "rsq_map.svh"
module rsq_assertions
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic low_supply_i,
	input wire logic aux_low_i,
	input wire logic wdg_underflow_i,
	input wire logic opt_lvd_en_i,
	input wire logic opt_pll_en_i,
	input wire logic irq_ack_i,
	input wire logic rst_pin_oe_o,
	input wire logic core_rst_n_o,
	input wire logic vec_fetch_o,
	input wire logic [15:0] vec_addr_o,
	input wire logic aux_irq_o,
	input wire logic pll_en_o,
	input wire logic osc_en_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence fetch_seq;
		(vec_addr_o == `RSQ_VEC_HI)
		##1 (vec_fetch_o && vec_addr_o == `RSQ_VEC_LO)
		##1 (!vec_fetch_o && core_rst_n_o);
	endsequence
	sequence wdg_out;
		rst_pin_oe_o [*3];
	endsequence
	a_fetch_order:
	assert property ($rose(vec_fetch_o) |-> fetch_seq)
		else $error("vector fetch order or length off");
	a_boot_vec:
	assert property ($rose(core_rst_n_o) |-> $past(vec_fetch_o))
		else $error("core released without vector fetch");
	a_lvd_hold:
	assert property ((low_supply_i && opt_lvd_en_i) [*3]
		|-> rst_pin_oe_o && !core_rst_n_o)
		else $error("low supply does not hold reset");
	a_wdg_pulse:
	assert property (wdg_underflow_i |-> ##2 wdg_out)
		else $error("watchdog pin pulse too short");
	a_pin_core:
	assert property (rst_pin_oe_o |-> !core_rst_n_o)
		else $error("pin driven while core runs");
	a_irq_ack:
	assert property (aux_irq_o && irq_ack_i && $stable(aux_low_i)
		|=> !aux_irq_o)
		else $error("pending request not cleared by ack");
	a_irq_run:
	assert property ($rose(aux_irq_o) |-> $past(core_rst_n_o))
		else $error("aux request raised during reset");
	a_osc_on:
	assert property (osc_en_o)
		else $error("oscillator stopped");
	a_pll_opt:
	assert property (opt_pll_en_i |=> pll_en_o)
		else $error("pll option ignored");
endmodule // rsq_assertions

// [rsq_pin_model.sv]
// External reset circuitry sharing the open-drain reset wire.
// Assumes a pull-up: the wire is low while any party pulls it.
`timescale 1ns/1ps
module rsq_pin_model
#(
	parameter int MIN_CYC = 3
)
(
	input wire logic clk_i,
	input wire logic oe_i,
	output logic pin_o
);
	logic pull = 1'h0;
	assign pin_o = !(oe_i || pull);
	task automatic hold(input int n);
		pull <= 1'h1;
		repeat ((n < MIN_CYC) ? MIN_CYC : n) @(posedge clk_i);
		pull <= 1'h0;
	endtask
endmodule // rsq_pin_model

// [rsq_tb.sv]
// Self-checking bench for rsq_top with its reset wire partner.
// Assumes the checker is bound below; 100 MHz clock.
`timescale 1ns/1ps
`include "rsq_map.svh"
module tb;
	logic clk_i = 1'h0, arst_n_i = 1'h0, low_supply_i = 1'h0;
	logic aux_low_i = 1'h0, wdg_underflow_i = 1'h0, irq_ack_i = 1'h0;
	logic opt_lvd_en_i = 1'h1, opt_long_dly_i = 1'h0, opt_pll_en_i = 1'h0;
	logic rst_pin_oe_o, core_rst_n_o, vec_fetch_o, aux_irq_o, rst_w;
	logic pll_en_o, osc_en_o, rst_pin_o;
	logic [15:0] vec_addr_o;
	logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int num_errors = 0, tests_run = 0, cyc = 0;
	always #5 clk_i = ~clk_i;
	rsq_pin_model i_pin (.clk_i, .oe_i(rst_pin_oe_o), .pin_o(rst_w));
	rsq_top i_dut (.clk_i, .arst_n_i, .rst_pin_i(rst_w), .rst_pin_o,
		.rst_pin_oe_o, .low_supply_i, .aux_low_i, .wdg_underflow_i,
		.opt_lvd_en_i, .opt_long_dly_i, .opt_pll_en_i, .irq_ack_i,
		.core_rst_n_o, .vec_fetch_o, .vec_addr_o, .aux_irq_o, .pll_en_o,
		.osc_en_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Ceiling well above the longest boot plus traffic
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			finish_test;
		end
	end
	task automatic chk(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		@(posedge clk_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		fork
			begin
				do @(posedge clk_i); while (s_axi_awready !== 1'h1);
				s_axi_awvalid <= 1'h0;
			end
			begin
				do @(posedge clk_i); while (s_axi_wready !== 1'h1);
				s_axi_wvalid <= 1'h0;
			end
		join
		do @(posedge clk_i); while (s_axi_bvalid !== 1'h1);
		r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_i); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_i); while (s_axi_rvalid !== 1'h1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	// Edges from now until the core is seen running
	task automatic boot(input int lo, hi);
		int k;
		k = 0;
		while (core_rst_n_o !== 1'h1 && k < 9000)
		begin
			@(posedge clk_i);
			k++;
		end
		chk(k >= lo && k <= hi, 1'h1);
	endtask
	task automatic ack;
		irq_ack_i <= 1'h1;
		@(posedge clk_i);
		irq_ack_i <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic t_regs;
		logic [31:0] d;
		logic [1:0] r;
		rd(`RSQ_OFF_SEQ, d, r);
		chk(d, 32'h1);
		wr(`RSQ_OFF_PLL, 32'h8, r);
		wt(2);
		chk(pll_en_o, 1'h1);
		rd(`RSQ_OFF_PLL, d, r);
		chk(d, 32'h58);
		wr(`RSQ_OFF_PLL, 32'h0, r);
		wt(2);
		chk(pll_en_o, 1'h0);
		opt_pll_en_i <= 1'h1;
		wt(2);
		chk(pll_en_o, 1'h1);
		opt_pll_en_i <= 1'h0;
		wr(32'hC, 32'h0, r);
		chk(r, `RSQ_RESP_SLVERR);
		rd(32'hC, d, r);
		chk(r, `RSQ_RESP_SLVERR);
	endtask
	task automatic t_aux;
		logic [31:0] d;
		logic [1:0] r;
		aux_low_i <= 1'h1;
		wt(3);
		chk(aux_irq_o, 1'h0);
		wr(`RSQ_OFF_ICS, 32'h0, r);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h20);
		wr(`RSQ_OFF_ICS, 32'h40, r);
		wt(2);
		chk(aux_irq_o, 1'h1);
		ack;
		chk(aux_irq_o, 1'h0);
		aux_low_i <= 1'h0;
		wt(3);
		chk(aux_irq_o, 1'h1);
		ack;
		wr(`RSQ_OFF_ICS, 32'h0, r);
		wr(`RSQ_OFF_ICS, 32'h40, r);
		wt(3);
		chk(aux_irq_o, 1'h0);
		aux_low_i <= 1'h1;
		wt(3);
		chk(aux_irq_o, 1'h1);
		wr(`RSQ_OFF_ICS, 32'h0, r);
		aux_low_i <= 1'h0;
		wt(3);
		chk(aux_irq_o, 1'h0);
	endtask
	task automatic t_lvd;
		logic [31:0] d;
		logic [1:0] r;
		opt_lvd_en_i <= 1'h0;
		low_supply_i <= 1'h1;
		aux_low_i <= 1'h1;
		wt(10);
		chk(core_rst_n_o, 1'h1);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h0);
		aux_low_i <= 1'h0;
		wr(`RSQ_OFF_ICS, 32'h40, r);
		opt_lvd_en_i <= 1'h1;
		wt(4);
		chk(core_rst_n_o, 1'h0);
		chk(rst_w, 1'h0);
		chk(rst_pin_o, 1'h0);
		// Aux crossing inside the reset must not raise a request
		aux_low_i <= 1'h1;
		low_supply_i <= 1'h0;
		wt(100);
		chk(rst_w, 1'h0);
		// A one-cycle dip inside the delay restarts the count
		low_supply_i <= 1'h1;
		@(posedge clk_i);
		low_supply_i <= 1'h0;
		boot(259, 266);
		chk(aux_irq_o, 1'h0);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h70);
		wr(`RSQ_OFF_ICS, 32'h10, r);
		aux_low_i <= 1'h0;
	endtask
	task automatic t_wdg;
		logic [31:0] d;
		logic [1:0] r;
		@(posedge clk_i);
		wdg_underflow_i <= 1'h1;
		@(posedge clk_i);
		wdg_underflow_i <= 1'h0;
		wt(3);
		chk(rst_w, 1'h0);
		boot(259, 270);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h11);
		fork
			i_pin.hold(5);
			begin
				#2;
				chk(core_rst_n_o, 1'h0);
			end
		join
		boot(258, 268);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h11);
		wr(`RSQ_OFF_ICS, 32'h0, r);
		rd(`RSQ_OFF_ICS, d, r);
		chk(d, 32'h0);
		opt_long_dly_i <= 1'h1;
		i_pin.hold(4);
		boot(4098, 4108);
		rd(`RSQ_OFF_SEQ, d, r);
		chk(d, 32'h3);
	endtask
	initial
	begin
		repeat (4) @(posedge clk_i);
		arst_n_i <= 1'h1;
		boot(260, 260);
		t_regs;
		t_aux;
		t_lvd;
		t_wdg;
		finish_test;
	end
endmodule // tb
bind rsq_top rsq_assertions i_chk (.clk_i, .arst_n_i, .low_supply_i,
	.aux_low_i, .wdg_underflow_i, .opt_lvd_en_i, .opt_pll_en_i, .irq_ack_i,
	.rst_pin_oe_o, .core_rst_n_o, .vec_fetch_o, .vec_addr_o, .aux_irq_o,
	.pll_en_o, .osc_en_o);
